/* File: core/bsc_map.svh */
// Instruction codes, register lengths and the instruction capture pattern of the test port
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH
`define BSC_IR_W        10
`define BSC_WORD_W      32
`define BSC_CFG_W       8
`define BSC_IR_CAPT     10'h001
`define BSC_IR_EXTEST   10'h000
`define BSC_IR_PULSECFG 10'h001
`define BSC_IR_CFGLOAD  10'h002
`define BSC_IR_SAMPLE   10'h005
`define BSC_IR_IDCODE   10'h006
`define BSC_IR_USERCODE 10'h007
`define BSC_IR_CLAMP    10'h00A
`define BSC_IR_HIGHZ    10'h00B
`define BSC_IR_CFGIO    10'h00D
`define BSC_IR_ANALYSER 10'h00E
`define BSC_IR_BYPASS   10'h3FF
`endif

/* File: core/bsc_pkg.sv */
// Types shared by the boundary-scan test port
package bsc_pkg;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bsc_tap_e;
  typedef enum logic [2:0] {
    DR_BYP, DR_ID, DR_USER, DR_BSR, DR_IOSTD, DR_LA, DR_CFG
  } bsc_dr_e;
  typedef struct packed {
    logic drive;
    logic hiz;
    logic cfgio;
  } bsc_pinmode_s;
  typedef struct packed {
    bsc_dr_e      dr;
    bsc_pinmode_s mode;
    logic         pins;
  } bsc_dec_s;
endpackage

/* File: core/bsc_boundary_scan_tap.sv */
// Boundary-scan test access port with configuration and analyser access
`timescale 1ns/100ps
`include "bsc_map.svh"

module bsc_boundary_scan_tap #(
  parameter int unsigned          NPIN    = 8,
  parameter int unsigned          IOSTD_W = 4,
  parameter int unsigned          LA_W    = 16,
  // Arbitrary identity value, bit 0 set
  parameter logic [31:0]          ID_VAL  = 32'h0ABC_0001,
  parameter logic [31:0]          USR_VAL = 32'hFFFF_FFFF
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rstn_i,
  input  wire logic                      tck_i,
  input  wire logic                      trst_n_i,
  input  wire logic                      tms_i,
  input  wire logic                      tdi_i,
  output logic                           tdo_o,
  output logic                           tdo_oe_o,
  input  wire logic                      cfg_busy_i,
  input  wire logic                      cfg_done_i,
  input  wire logic [NPIN-1:0]           core_out_i,
  input  wire logic [NPIN-1:0]           core_oe_i,
  input  wire logic [NPIN-1:0]           pin_in_i,
  input  wire logic [LA_W-1:0]           la_status_i,
  output logic [NPIN-1:0]                pin_out_o,
  output logic [NPIN-1:0]                pin_oe_o,
  output logic [NPIN*IOSTD_W-1:0]        iostd_o,
  output logic [LA_W-1:0]                la_cmd_o,
  output logic [`BSC_CFG_W-1:0]          cfg_byte_o,
  output logic                           cfg_byte_vld_o,
  output logic                           cfg_restart_o,
  output logic                           cfg_hold_o
);
  import bsc_pkg::*;

  localparam int unsigned BSR_W = 3 * NPIN;
  localparam int unsigned IOS_W = NPIN * IOSTD_W;

  bsc_tap_e                st_ff, nxt_st;
  logic [`BSC_IR_W-1:0]    ir_sr_ff, ir_ff;
  logic                    byp_ff;
  logic [`BSC_WORD_W-1:0]  word_sr_ff;
  logic [BSR_W-1:0]        bsr_ff;
  logic [2*NPIN-1:0]       bsr_upd_ff;
  logic [IOS_W-1:0]        ios_sr_ff, ios_upd_ff;
  logic [LA_W-1:0]         la_sr_ff, la_upd_ff;
  logic [`BSC_CFG_W-1:0]   cfg_sr_ff, cfg_word_ff;
  logic [2:0]              cfg_cnt_ff;
  logic [NPIN-1:0]         pin_s1_ff, pin_s2_ff;
  logic                    busy_s1_ff, busy_s2_ff;
  logic                    upd_tgl_ff, cfg_tgl_ff, rst_tgl_ff;
  bsc_pinmode_s            mode_t_ff, mode_c_ff;
  bsc_dec_s                dec, raw;
  logic                    dr_bit, upd_ev;
  logic [`BSC_IR_W-1:0]    nxt_ir;

  function automatic bsc_dec_s bsc_decode(input logic [`BSC_IR_W-1:0] ir,
                                          input logic busy);
    bsc_dec_s d;
    d = '{dr: DR_BYP, mode: 3'b000, pins: 1'b0};
    case (ir)
      `BSC_IR_SAMPLE:
      begin
        d.dr   = DR_BSR;
        d.pins = 1'b1;
      end
      `BSC_IR_EXTEST:
        if (!busy)
        begin
          d.dr         = DR_BSR;
          d.mode.drive = 1'b1;
          d.pins       = 1'b1;
        end
      `BSC_IR_IDCODE:   d.dr = DR_ID;
      `BSC_IR_USERCODE: d.dr = DR_USER;
      `BSC_IR_CLAMP:    d.mode.drive = !busy;
      `BSC_IR_HIGHZ:    d.mode.hiz = !busy;
      `BSC_IR_CFGIO:
      begin
        d.dr         = DR_IOSTD;
        d.mode.cfgio = 1'b1;
      end
      `BSC_IR_ANALYSER: d.dr = DR_LA;
      `BSC_IR_CFGLOAD:  d.dr = DR_CFG;
      default:          d.dr = DR_BYP;
    endcase
    return d;
  endfunction

  assign dec = bsc_decode(ir_ff, busy_s2_ff);
  // Instruction about to take effect, busy ignored; core gates busy itself
  assign nxt_ir = (st_ff == ST_UPD_IR) ? ir_sr_ff : ir_ff;
  assign raw    = bsc_decode(nxt_ir, 1'b0);

  // Test port state machine
  always_comb
  begin
    case (st_ff)
      ST_RESET:  nxt_st = tms_i ? ST_RESET  : ST_IDLE;
      ST_IDLE:   nxt_st = tms_i ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nxt_st = tms_i ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_st = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  nxt_st = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_st = tms_i ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nxt_st = tms_i ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt_st = tms_i ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_st = tms_i ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nxt_st = tms_i ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: nxt_st = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  nxt_st = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_st = tms_i ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt_st = tms_i ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt_st = tms_i ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_st = tms_i ? ST_SEL_DR : ST_IDLE;
      default:   nxt_st = ST_RESET;
    endcase
  end

  always_ff @(posedge tck_i or negedge trst_n_i)
    if (!trst_n_i)
      st_ff <= ST_RESET;
    else
      st_ff <= nxt_st;

  // Pin levels and the core's busy flag are foreign to the test clock
  always_ff @(posedge tck_i or negedge trst_n_i)
    if (!trst_n_i)
    begin
      pin_s1_ff  <= '0;
      pin_s2_ff  <= '0;
      busy_s1_ff <= 1'b0;
      busy_s2_ff <= 1'b0;
    end
    else
    begin
      pin_s1_ff  <= pin_in_i;
      pin_s2_ff  <= pin_s1_ff;
      busy_s1_ff <= cfg_busy_i;
      busy_s2_ff <= busy_s1_ff;
    end

  // Instruction path
  always_ff @(posedge tck_i or negedge trst_n_i)
    if (!trst_n_i)
    begin
      ir_sr_ff <= `BSC_IR_CAPT;
      ir_ff    <= `BSC_IR_IDCODE;
    end
    else if (st_ff == ST_RESET)
      ir_ff <= `BSC_IR_IDCODE;
    else if (st_ff == ST_CAP_IR)
      ir_sr_ff <= `BSC_IR_CAPT;
    else if (st_ff == ST_SH_IR)
      ir_sr_ff <= {tdi_i, ir_sr_ff[`BSC_IR_W-1:1]};
    else if (st_ff == ST_UPD_IR)
      ir_ff <= ir_sr_ff;

  // Bypass and identity/user word
  always_ff @(posedge tck_i or negedge trst_n_i)
    if (!trst_n_i)
    begin
      byp_ff     <= 1'b0;
      word_sr_ff <= '0;
    end
    else if (st_ff == ST_CAP_DR)
    begin
      byp_ff     <= 1'b0;
      word_sr_ff <= (dec.dr == DR_USER) ? USR_VAL : ID_VAL;
    end
    else if (st_ff == ST_SH_DR)
    begin
      byp_ff     <= tdi_i;
      word_sr_ff <= {tdi_i, word_sr_ff[`BSC_WORD_W-1:1]};
    end

  // Boundary cells: pins low, outputs, then enables
  always_ff @(posedge tck_i or negedge trst_n_i)
    if (!trst_n_i)
    begin
      bsr_ff     <= '0;
      bsr_upd_ff <= '0;
    end
    else if (dec.dr == DR_BSR)
    begin
      if (st_ff == ST_CAP_DR)
        bsr_ff <= {bsr_upd_ff, pin_s2_ff};
      else if (st_ff == ST_SH_DR)
        bsr_ff <= {tdi_i, bsr_ff[BSR_W-1:1]};
      else if (st_ff == ST_UPD_DR)
        bsr_upd_ff <= bsr_ff[BSR_W-1:NPIN];
    end

  // I/O standard and analyser registers
  always_ff @(posedge tck_i or negedge trst_n_i)
    if (!trst_n_i)
    begin
      ios_sr_ff  <= '0;
      ios_upd_ff <= '0;
      la_sr_ff   <= '0;
      la_upd_ff  <= '0;
    end
    else if (dec.dr == DR_IOSTD)
    begin
      if (st_ff == ST_CAP_DR)
        ios_sr_ff <= ios_upd_ff;
      else if (st_ff == ST_SH_DR)
        ios_sr_ff <= {tdi_i, ios_sr_ff[IOS_W-1:1]};
      else if (st_ff == ST_UPD_DR)
        ios_upd_ff <= ios_sr_ff;
    end
    else if (dec.dr == DR_LA)
    begin
      if (st_ff == ST_CAP_DR)
        la_sr_ff <= la_status_i;
      else if (st_ff == ST_SH_DR)
        la_sr_ff <= {tdi_i, la_sr_ff[LA_W-1:1]};
      else if (st_ff == ST_UPD_DR)
        la_upd_ff <= la_sr_ff;
    end

  // Configuration stream, LSB first, one toggle per byte
  always_ff @(posedge tck_i or negedge trst_n_i)
    if (!trst_n_i)
    begin
      cfg_sr_ff   <= '0;
      cfg_word_ff <= '0;
      cfg_cnt_ff  <= '0;
      cfg_tgl_ff  <= 1'b0;
    end
    else if (dec.dr == DR_CFG && st_ff == ST_SH_DR)
    begin
      cfg_sr_ff  <= {tdi_i, cfg_sr_ff[`BSC_CFG_W-1:1]};
      cfg_cnt_ff <= cfg_cnt_ff + 3'h1;
      if (cfg_cnt_ff == 3'h7)
      begin
        cfg_word_ff <= {tdi_i, cfg_sr_ff[`BSC_CFG_W-1:1]};
        cfg_tgl_ff  <= ~cfg_tgl_ff;
      end
    end
    else if (st_ff == ST_CAP_DR)
      cfg_cnt_ff <= '0;

  // Pin mode and restart events handed to the core clock
  assign upd_ev = (st_ff == ST_UPD_IR) || (st_ff == ST_UPD_DR) ||
                  (st_ff == ST_RESET && ir_ff != `BSC_IR_IDCODE);

  always_ff @(posedge tck_i or negedge trst_n_i)
    if (!trst_n_i)
    begin
      upd_tgl_ff <= 1'b0;
      rst_tgl_ff <= 1'b0;
      mode_t_ff  <= '0;
    end
    else
    begin
      if (upd_ev)
        upd_tgl_ff <= ~upd_tgl_ff;
      if (st_ff == ST_RESET)
        mode_t_ff <= '0;
      else if (upd_ev)
        mode_t_ff <= raw.mode;
      if (st_ff == ST_UPD_IR && ir_sr_ff == `BSC_IR_PULSECFG)
        rst_tgl_ff <= ~rst_tgl_ff;
    end

  // Serial output on the falling test clock edge
  always_comb
  begin
    case (dec.dr)
      DR_ID, DR_USER: dr_bit = word_sr_ff[0];
      DR_BSR:         dr_bit = bsr_ff[0];
      DR_IOSTD:       dr_bit = ios_sr_ff[0];
      DR_LA:          dr_bit = la_sr_ff[0];
      DR_CFG:         dr_bit = cfg_sr_ff[0];
      default:        dr_bit = byp_ff;
    endcase
  end

  always_ff @(negedge tck_i or negedge trst_n_i)
    if (!trst_n_i)
    begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else
    begin
      tdo_o    <= (st_ff == ST_SH_IR) ? ir_sr_ff[0] : dr_bit;
      tdo_oe_o <= (st_ff == ST_SH_IR) || (st_ff == ST_SH_DR);
    end

  // Core side: toggle synchronisers, edge taken from stages two and three
  logic [2:0] sy1_ff, sy2_ff, sy3_ff, edge_c;
  logic [2*NPIN-1:0] bsr_c_ff;
  logic drv_c, hiz_c;

  always_ff @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      sy1_ff <= '0;
      sy2_ff <= '0;
      sy3_ff <= '0;
    end
    else
    begin
      sy1_ff <= {rst_tgl_ff, cfg_tgl_ff, upd_tgl_ff};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
    end

  assign edge_c = sy2_ff ^ sy3_ff;
  assign drv_c  = mode_c_ff.drive && !cfg_busy_i;
  assign hiz_c  = mode_c_ff.hiz && !cfg_busy_i;

  always_ff @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      mode_c_ff <= '0;
      bsr_c_ff  <= '0;
      iostd_o   <= '0;
      la_cmd_o  <= '0;
    end
    else if (edge_c[0])
    begin
      mode_c_ff <= mode_t_ff;
      bsr_c_ff  <= bsr_upd_ff;
      iostd_o   <= ios_upd_ff;
      la_cmd_o  <= la_upd_ff;
    end

  always_ff @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      pin_out_o <= '0;
      pin_oe_o  <= '0;
    end
    else if (hiz_c)
      pin_oe_o <= '0;
    else if (drv_c)
    begin
      pin_out_o <= bsr_c_ff[NPIN-1:0];
      pin_oe_o  <= bsr_c_ff[2*NPIN-1:NPIN];
    end
    else
    begin
      pin_out_o <= core_out_i;
      pin_oe_o  <= cfg_done_i ? core_oe_i : '0;
    end

  always_ff @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      cfg_byte_o     <= '0;
      cfg_byte_vld_o <= 1'b0;
      cfg_restart_o  <= 1'b0;
      cfg_hold_o     <= 1'b0;
    end
    else
    begin
      cfg_byte_vld_o <= edge_c[1];
      if (edge_c[1])
        cfg_byte_o <= cfg_word_ff;
      cfg_restart_o <= edge_c[2];
      if (edge_c[0] && mode_t_ff.cfgio)
        cfg_hold_o <= 1'b1;
      else if (edge_c[2])
        cfg_hold_o <= 1'b0;
    end

  sequence s_shift_byp;
    st_ff == ST_SH_DR && dec.dr == DR_BYP;
  endsequence

  a_tap_reset_walk: assert property (@(posedge tck_i)
    disable iff (!trst_n_i)
    tms_i [*5] |=> st_ff == ST_RESET)
    else $error("five TMS highs did not reach reset");
  a_reset_selects_id: assert property (@(posedge tck_i)
    disable iff (!trst_n_i)
    st_ff == ST_RESET ##1 st_ff == ST_RESET |-> dec.dr == DR_ID)
    else $error("reset state did not select identity");
  a_ir_capture_pat: assert property (@(posedge tck_i)
    disable iff (!trst_n_i)
    st_ff == ST_CAP_IR |=> ir_sr_ff == `BSC_IR_CAPT)
    else $error("instruction capture pattern wrong");
  a_bypass_one_stage: assert property (@(posedge tck_i)
    disable iff (!trst_n_i)
    s_shift_byp ##1 s_shift_byp |-> byp_ff == $past(tdi_i))
    else $error("bypass delay is not one stage");
  a_id_capture_val: assert property (@(posedge tck_i)
    disable iff (!trst_n_i)
    st_ff == ST_CAP_DR && dec.dr == DR_ID |=> word_sr_ff == ID_VAL)
    else $error("identity value not captured");
  a_user_capture_val: assert property (@(posedge tck_i)
    disable iff (!trst_n_i)
    st_ff == ST_CAP_DR && dec.dr == DR_USER |=> word_sr_ff == USR_VAL)
    else $error("user code not captured");
  a_pins_snapshot: assert property (@(posedge tck_i)
    disable iff (!trst_n_i)
    st_ff == ST_CAP_DR && dec.pins
    |=> bsr_ff[NPIN-1:0] == $past(pin_s2_ff))
    else $error("pin snapshot not captured");
  a_busy_no_drive: assert property (@(posedge tck_i)
    disable iff (!trst_n_i)
    busy_s2_ff |-> !dec.mode.drive && !dec.mode.hiz)
    else $error("pin test allowed while configuring");
  a_highz_float: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    hiz_c |=> pin_oe_o == '0)
    else $error("pins driven under highz");
  a_unconf_undriven: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    !cfg_done_i && !drv_c |=> pin_oe_o == '0)
    else $error("pins driven before configuration");
  a_cfg_byte_pulse: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    cfg_byte_vld_o |=> !cfg_byte_vld_o)
    else $error("byte strobe longer than one cycle");
endmodule

/* File: bench/bsc_tap_ctl.sv */
// Test controller model driving the serial test port
`timescale 1ns/100ps
module bsc_tap_ctl (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // One clock pulse; the clock rests low between calls
  task automatic step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #6;
    q = tdo_oe_i ? tdo_i : 1'bx;
    tck_o = 1'b1;
    #6;
    tck_o = 1'b0;
  endtask

  // Idle data line toggles so no stale level is mistaken for data
  task automatic move(input logic m);
    logic q;
    step(m, ~tdi_o, q);
  endtask

  task automatic tap_reset;
    repeat (5) move(1'b1);
    move(1'b0);
  endtask

  // Idle to shift, n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    move(1'b1);
    if (ir)
      move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    move(1'b1);
    move(1'b0);
  endtask
endmodule

/* File: bench/boundary_scan_tap_bench.sv */
// Self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
`include "bsc_map.svh"
module boundary_scan_tap_bench;
  logic        core_clk_i = 1'b0;
  logic        rstn_i     = 1'b0;
  logic        trst_n_i   = 1'b0;
  logic        cfg_busy_i = 1'b0;
  logic        cfg_done_i = 1'b0;
  logic [7:0]  core_out_i = 8'h3C;
  logic [7:0]  core_oe_i  = 8'hF0;
  logic [7:0]  pin_in_i   = 8'h96;
  logic [15:0] la_status_i = 16'hC3A5;
  wire         tck, tms, tdi, tdo, tdo_oe;
  logic [7:0]  pin_out_o, pin_oe_o, cfg_byte_o;
  logic [31:0] iostd_o;
  logic [15:0] la_cmd_o;
  logic        cfg_byte_vld_o, cfg_restart_o, cfg_hold_o;
  logic [31:0] d;
  int          err_total = 0;
  int          cmp_count = 0;
  int          nbytes = 0;
  int          nrst = 0;
  logic [7:0]  last_byte = 8'h00;

  always #2 core_clk_i = ~core_clk_i;

  bsc_boundary_scan_tap u_dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .tck_i(tck),
    .trst_n_i(trst_n_i), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .cfg_busy_i(cfg_busy_i), .cfg_done_i(cfg_done_i),
    .core_out_i(core_out_i), .core_oe_i(core_oe_i), .pin_in_i(pin_in_i),
    .la_status_i(la_status_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .iostd_o(iostd_o), .la_cmd_o(la_cmd_o), .cfg_byte_o(cfg_byte_o),
    .cfg_byte_vld_o(cfg_byte_vld_o), .cfg_restart_o(cfg_restart_o),
    .cfg_hold_o(cfg_hold_o));

  bsc_tap_ctl u_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
    .tdo_oe_i(tdo_oe));

  // Count one-cycle pulses from the core side, mid-cycle where they stand
  always @(negedge core_clk_i)
  begin
    if (cfg_byte_vld_o === 1'b1)
    begin
      nbytes++;
      last_byte = cfg_byte_o;
    end
    if (cfg_restart_o === 1'b1)
      nrst++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cwait;
    repeat (8) @(negedge core_clk_i);
  endtask

  task automatic ir(input logic [9:0] code);
    u_ctl.scan(1'b1, 10, {22'h0, code}, d);
    chk(d, {22'h0, `BSC_IR_CAPT}, "ir capture");
    cwait;
  endtask

  task automatic t_reset;
    chk(pin_oe_o, 8'h00, "oe before config");
    @(negedge core_clk_i);
    cfg_done_i = 1'b1;
    cwait;
    chk(pin_oe_o, core_oe_i, "oe released");
    chk(pin_out_o, core_out_i, "out released");
  endtask

  task automatic t_id;
    u_ctl.tap_reset;
    u_ctl.scan(1'b0, 32, 32'h0, d);
    chk(d, 32'h0ABC_0001, "id after reset");
    ir(`BSC_IR_IDCODE);
    u_ctl.scan(1'b0, 32, 32'h0, d);
    chk(d, 32'h0ABC_0001, "id");
    ir(`BSC_IR_USERCODE);
    u_ctl.scan(1'b0, 32, 32'h0, d);
    chk(d, 32'hFFFF_FFFF, "user");
  endtask

  task automatic t_bypass;
    logic [9:0] codes [2] = '{`BSC_IR_BYPASS, 10'h155};
    foreach (codes[i])
    begin
      ir(codes[i]);
      u_ctl.scan(1'b0, 8, 32'hB3, d);
      chk(d, 32'h66, "bypass delay");
    end
  endtask

  task automatic t_sample;
    ir(`BSC_IR_SAMPLE);
    u_ctl.scan(1'b0, 24, 32'hA55A00, d);
    chk(d[7:0], 8'h96, "sample capture");
    cwait;
    chk(pin_out_o, core_out_i, "sample no effect");
    chk(pin_oe_o, core_oe_i, "sample no effect oe");
  endtask

  task automatic t_extest;
    ir(`BSC_IR_EXTEST);
    chk(pin_out_o, 8'h5A, "extest out");
    chk(pin_oe_o, 8'hA5, "extest oe");
    @(negedge core_clk_i);
    pin_in_i = 8'h69;
    u_ctl.scan(1'b0, 24, 32'hA55A00, d);
    chk(d[7:0], 8'h69, "extest capture");
    chk(d[23:8], 16'hA55A, "extest cells reload");
  endtask

  task automatic t_hiz;
    ir(`BSC_IR_HIGHZ);
    chk(pin_oe_o, 8'h00, "highz");
    ir(`BSC_IR_CLAMP);
    chk(pin_out_o, 8'h5A, "clamp out");
    chk(pin_oe_o, 8'hA5, "clamp oe");
    u_ctl.scan(1'b0, 4, 32'hD, d);
    chk(d, 32'hA, "clamp bypass");
  endtask

  task automatic t_busy;
    u_ctl.tap_reset;
    @(negedge core_clk_i);
    cfg_busy_i = 1'b1;
    cwait;
    ir(`BSC_IR_EXTEST);
    chk(pin_out_o, core_out_i, "busy refuse out");
    chk(pin_oe_o, core_oe_i, "busy refuse oe");
    @(negedge core_clk_i);
    cfg_busy_i = 1'b0;
    u_ctl.tap_reset;
    cwait;
  endtask

  task automatic t_cfg;
    int n0;
    n0 = nbytes;
    ir(`BSC_IR_CFGLOAD);
    u_ctl.scan(1'b0, 12, 32'hFA5, d);
    cwait;
    chk(nbytes - n0, 1, "byte count");
    chk(last_byte, 8'hA5, "byte value");
  endtask

  task automatic t_iostd;
    int r0;
    r0 = nrst;
    ir(`BSC_IR_CFGIO);
    chk(cfg_hold_o, 1'b1, "hold set");
    u_ctl.scan(1'b0, 32, 32'h1234ABCD, d);
    cwait;
    chk(iostd_o, 32'h1234ABCD, "iostd");
    ir(`BSC_IR_PULSECFG);
    chk(nrst - r0, 1, "restart pulse");
    chk(cfg_hold_o, 1'b0, "hold cleared");
  endtask

  task automatic t_la;
    ir(`BSC_IR_ANALYSER);
    u_ctl.scan(1'b0, 16, 32'h5AF0, d);
    cwait;
    chk(d, 32'hC3A5, "analyser status");
    chk(la_cmd_o, 16'h5AF0, "analyser cmd");
  endtask

  initial
  begin
    #100000;
    err_total++;
    final_report;
  end

  initial
  begin
    repeat (2) @(negedge core_clk_i);
    rstn_i = 1'b1;
    trst_n_i = 1'b1;
    #1.3;
    t_reset;
    t_id;
    t_bypass;
    t_sample;
    t_extest;
    t_hiz;
    t_busy;
    t_cfg;
    t_iostd;
    t_la;
    final_report;
  end
endmodule
